// file: verilog/msp_pkg.sv
// Constants, register map and timing for the monitor sync processor.
// Assumes clk_i is the oscillator at 100 MHz and all sync inputs are
// already synchronous to it.
package msp_pkg;
  localparam logic [7:0] ADDR_CTRL_ZERO = 8'h00;
  localparam logic [7:0] ADDR_CTRL_ONE  = 8'h04;
  localparam logic [7:0] ADDR_CTRL_TWO  = 8'h08;
  localparam logic [7:0] ADDR_DIVISOR   = 8'h0C;
  // Field positions
  localparam int Z_INSEL  = 7;
  localparam int Z_RAW    = 6;
  localparam int Z_CMP    = 5;
  localparam int O_HPOL   = 0;
  localparam int O_VPOL   = 1;
  localparam int O_HINV   = 2;
  localparam int O_VINV   = 3;
  localparam int O_CPOL   = 4;
  localparam int O_PORCH  = 5;
  localparam int O_CSG    = 6;
  localparam int T_OUTDIS = 0;
  localparam int T_CPRES  = 1;
  localparam int T_GREEN  = 2;
  localparam int T_LATCH  = 3;
  localparam int T_PSDIS  = 4;
  localparam int T_CLKSEL = 5;
  localparam int T_VDD    = 6;
  localparam int T_UNMIX  = 7;
  // Reset values; pseudo generation off so outputs start as pass-through
  localparam logic [7:0] CTRL_ZERO_RST = 8'h00;
  localparam logic [7:0] CTRL_ONE_RST  = 8'h00;
  localparam logic [7:0] CTRL_TWO_RST  = 8'h10;
  localparam logic [7:0] DIVISOR_RST   = 8'h7F;
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam logic [1:0] FSYNC_DIV3 = 2'h2;
  localparam logic [1:0] FSYNC_DIV2 = 2'h1;
  localparam int HS_MAX_NS = 7850;
  localparam logic [4:0] UD_MAX = 5'h1F;
  localparam logic [4:0] UD_MIN = 5'h00;
  localparam logic [9:0] INTERVAL_LAST = 10'h3E7;
  localparam logic [3:0] POL_LAST = 4'hF;
  localparam logic [4:0] POL_HALF = 5'h08;
  localparam int GREEN_DELAY_NS = 150;
  localparam int GREEN_DELAY_CYC = GREEN_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [5:0] GREEN_EDGE_LAST = 6'h3F;
  localparam logic [5:0] GREEN_MISMATCH = 6'h20;
  localparam logic [7:0] PH_WIDTH = 8'h08;
  localparam logic [9:0] PV_LINES = 10'h210;
  localparam logic [9:0] PV_WIDTH = 10'h006;
  localparam logic [3:0] CLAMP_W1 = 4'h2;
  localparam logic [3:0] CLAMP_W2 = 4'h4;
  localparam logic [3:0] CLAMP_W3 = 4'h8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// file: verilog/msp_sync_proc.sv
// Sync processor core with its AXI4-Lite register slave.
// Assumes sync inputs are synchronous to clk_i, which is the oscillator.
//
// Implementation choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module msp_sync_proc
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [7:0] s_axi_awaddr_i,
  input  wire logic       s_axi_awvalid_i,
  output logic            s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0] s_axi_wstrb_i,
  input  wire logic       s_axi_wvalid_i,
  output logic            s_axi_wready_o,
  output logic [1:0]      s_axi_bresp_o,
  output logic            s_axi_bvalid_o,
  input  wire logic       s_axi_bready_i,
  input  wire logic [7:0] s_axi_araddr_i,
  input  wire logic       s_axi_arvalid_i,
  output logic            s_axi_arready_o,
  output logic [31:0]     s_axi_rdata_o,
  output logic [1:0]      s_axi_rresp_o,
  output logic            s_axi_rvalid_o,
  input  wire logic       s_axi_rready_i,
  input  wire logic       hsync_i,
  input  wire logic       vsync_i,
  input  wire logic       csync_i,
  output logic            hsync_o,
  output logic            vsync_o,
  output logic            clamp_o,
  output logic            vdd_level_sel_o
);

  function automatic logic reg_hit(input logic [7:0] a,
                                   input logic [7:0] off);
    reg_hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic logic [3:0] clamp_len(input logic [1:0] csg);
    case (csg)
      2'h1:    clamp_len = msp_pkg::CLAMP_W1;
      2'h2:    clamp_len = msp_pkg::CLAMP_W2;
      2'h3:    clamp_len = msp_pkg::CLAMP_W3;
      default: clamp_len = 4'h0;
    endcase
  endfunction

  // Software-written control
  logic [7:0] zero_r;
  logic [7:0] one_r;
  logic [7:0] two_r;
  logic [7:0] div_r;
  // Bus state
  logic        awready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;
  // Core state
  logic [1:0] fdiv_r;
  logic [4:0] ud_cnt_r;
  logic       vext_r;
  logic       latch_r;
  logic       sel_prev_r;
  logic       mix_seen_r;
  logic       unmix_r;
  logic [9:0] itv_r;
  logic [3:0] win_r;
  logic [4:0] hi_h_r;
  logic [4:0] hi_v_r;
  logic       hpol_r;
  logic       vpol_r;
  logic       c_prev_r;
  logic       cseen_r;
  logic       cpres_r;
  logic [msp_pkg::GREEN_DELAY_CYC-1:0] dly_r;
  logic       hn_prev_r;
  logic [5:0] mis_r;
  logic [5:0] cedge_r;
  logic       green_r;
  logic [3:0] clamp_cnt_r;
  logic [7:0] ph_r;
  logic [9:0] pv_r;
  logic       hs_r;
  logic       vs_r;
  logic       clamp_r;

  // Bus decode
  wire wr_fire = awready_r & s_axi_awvalid_i & s_axi_wvalid_i;
  wire wr_lane = wr_fire & s_axi_wstrb_i[0];
  wire [7:0] wd = s_axi_wdata_i[7:0];
  wire wr_zero = wr_lane & reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_ZERO);
  wire wr_one  = wr_lane & reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_ONE);
  wire wr_two  = wr_lane & reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_TWO);
  wire wr_div  = wr_lane & reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_DIVISOR);
  wire wr_map  = reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_ZERO)
               | reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_ONE)
               | reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_CTRL_TWO)
               | reg_hit(s_axi_awaddr_i, msp_pkg::ADDR_DIVISOR);
  wire rd_fire = arready_r & s_axi_arvalid_i;
  wire rd_two  = rd_fire & reg_hit(s_axi_araddr_i, msp_pkg::ADDR_CTRL_TWO);

  // Control fields
  wire insel  = zero_r[msp_pkg::Z_INSEL];
  wire cmp    = zero_r[msp_pkg::Z_CMP];
  wire hinv   = one_r[msp_pkg::O_HINV];
  wire vinv   = one_r[msp_pkg::O_VINV];
  wire cpol   = one_r[msp_pkg::O_CPOL];
  wire porch  = one_r[msp_pkg::O_PORCH];
  wire [1:0] csg = one_r[msp_pkg::O_CSG+1:msp_pkg::O_CSG];
  wire outdis = two_r[msp_pkg::T_OUTDIS];
  wire psdis  = two_r[msp_pkg::T_PSDIS];
  wire clksel = two_r[msp_pkg::T_CLKSEL];

  // Counter clock: oscillator over three or over two
  wire [1:0] flim = clksel ? msp_pkg::FSYNC_DIV2 : msp_pkg::FSYNC_DIV3;
  wire ftick = (fdiv_r == flim);

  // Up/down counter on the selected input; at a third or half of the oscillator its 31 steps
  // take 930 or 620 ns, well short of HS_MAX_NS, before it saturates
  wire sel_in = insel ? csync_i : hsync_i;
  wire ud_up  = ftick & sel_in & (ud_cnt_r != msp_pkg::UD_MAX);
  wire ud_dn  = ftick & ~sel_in & (ud_cnt_r != msp_pkg::UD_MIN);
  wire [4:0] ud_nxt = ud_up ? ud_cnt_r + 5'h01 :
                      ud_dn ? ud_cnt_r - 5'h01 : ud_cnt_r;
  wire vext_nxt = (ud_cnt_r == msp_pkg::UD_MAX) ? 1'b1 :
                  (ud_cnt_r == msp_pkg::UD_MIN) ? 1'b0 : vext_r;
  wire latch_set = (vext_nxt != vext_r);
  // Set beats a software clear in the same cycle
  wire latch_nxt = latch_set |
                   (latch_r & ~(wr_two & ~wd[msp_pkg::T_LATCH]));

  // Horizontal period tracking for the unmixed flag
  wire sel_rise = sel_in & ~sel_prev_r;
  wire unmix_set = cmp & sel_rise & ~mix_seen_r & ~vext_r;
  wire unmix_nxt = cmp & ~vext_r &
                   (unmix_set | (unmix_r & ~rd_two));

  // Interval timer and polarity window
  wire itick = (itv_r == msp_pkg::INTERVAL_LAST);
  wire wend  = itick & (win_r == msp_pkg::POL_LAST);
  wire [4:0] hi_h_sum = hi_h_r + {4'h0, hsync_i};
  wire [4:0] hi_v_sum = hi_v_r + {4'h0, vsync_i};
  wire c_edge = csync_i ^ c_prev_r;
  // Counting rises, one per line, leaves room for 33 of 64 mismatches
  wire c_rise = csync_i & ~c_prev_r;

  // Horizontal input normalised to positive using detected polarity
  wire hn = hsync_i ^ ~hpol_r;
  wire hn_rise = hn & ~hn_prev_r;
  wire hn_fall = ~hn & hn_prev_r;
  wire mismatch = hn_rise &
                  (dly_r[msp_pkg::GREEN_DELAY_CYC-1] != hn);
  wire green_clr = wr_two & ~wd[msp_pkg::T_GREEN];
  wire green_set = mismatch & (mis_r == msp_pkg::GREEN_MISMATCH);
  wire green_nxt = green_set | (green_r & ~green_clr);

  // Clamp trigger follows the output porch choice; detected sync on green forces the back porch
  wire back = green_r | porch;
  wire clamp_go = (back ? hn_fall : hn_rise) & (csg != 2'h0);
  wire clamp_act = (clamp_cnt_r != 4'h0);

  // Pseudo sync generator
  wire ph_wrap = ftick & (ph_r >= div_r - 8'h01);
  wire ph_pulse = (ph_r < msp_pkg::PH_WIDTH);
  wire pv_pulse = (pv_r < msp_pkg::PV_WIDTH);

  // Output selection; composite path is blanked during extraction
  wire blank = cmp & vext_r;
  wire hs_pass = (sel_in & ~blank) ^ hinv;
  wire vs_pass = (cmp ? vext_r : vsync_i) ^ vinv;
  wire hs_src = psdis ? hs_pass : ph_pulse;
  wire vs_src = psdis ? vs_pass : pv_pulse;

  // Read mux
  wire [7:0] rd_zero = {insel, sel_in, cmp, ud_cnt_r};
  wire [7:0] rd_one  = {one_r[7:2], vpol_r, hpol_r};
  wire [7:0] rd_tw   = {unmix_r, two_r[6:4], latch_r, green_r,
                        cpres_r, outdis};
  wire ra0 = reg_hit(s_axi_araddr_i, msp_pkg::ADDR_CTRL_ZERO);
  wire ra1 = reg_hit(s_axi_araddr_i, msp_pkg::ADDR_CTRL_ONE);
  wire ra2 = reg_hit(s_axi_araddr_i, msp_pkg::ADDR_CTRL_TWO);
  wire ra3 = reg_hit(s_axi_araddr_i, msp_pkg::ADDR_DIVISOR);
  wire [7:0] rd_byte = ra0 ? rd_zero : ra1 ? rd_one :
                       ra2 ? rd_tw : ra3 ? div_r : 8'h00;
  wire rd_map = ra0 | ra1 | ra2 | ra3;

  // AXI4-Lite write channel: both address and data must be present
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= msp_pkg::RESP_OKAY;
    end
    else
    begin
      awready_r <= s_axi_awvalid_i & s_axi_wvalid_i & ~awready_r & ~bvalid_r;
      if (wr_fire)
      begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_map ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready_i)
        bvalid_r <= 1'b0;
    end
  end

  // AXI4-Lite read channel
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= msp_pkg::RESP_OKAY;
      rdata_r   <= 32'h0000_0000;
    end
    else
    begin
      arready_r <= s_axi_arvalid_i & ~arready_r & ~rvalid_r;
      if (rd_fire)
      begin
        rvalid_r <= 1'b1;
        rdata_r  <= {24'h00_0000, rd_byte};
        rresp_r  <= rd_map ? msp_pkg::RESP_OKAY : msp_pkg::RESP_SLVERR;
      end
      else if (s_axi_rready_i)
        rvalid_r <= 1'b0;
    end
  end

  // Control registers; read-only fields are held outside these
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      zero_r <= msp_pkg::CTRL_ZERO_RST;
      one_r  <= msp_pkg::CTRL_ONE_RST;
      two_r  <= msp_pkg::CTRL_TWO_RST;
      div_r  <= msp_pkg::DIVISOR_RST;
    end
    else
    begin
      if (wr_zero)
        zero_r <= wd & 8'hA0;
      if (wr_one)
        one_r <= wd & 8'hFC;
      if (wr_two)
        two_r <= wd & 8'h71;
      if (wr_div)
        div_r <= wd;
    end
  end

  // Counter clock divider, up/down counter and extraction flags
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fdiv_r     <= 2'h0;
      ud_cnt_r   <= msp_pkg::UD_MIN;
      vext_r     <= 1'b0;
      latch_r    <= 1'b0;
      sel_prev_r <= 1'b0;
      mix_seen_r <= 1'b0;
      unmix_r    <= 1'b0;
    end
    else
    begin
      fdiv_r     <= ftick ? 2'h0 : fdiv_r + 2'h1;
      ud_cnt_r   <= ud_nxt;
      vext_r     <= vext_nxt;
      latch_r    <= latch_nxt;
      sel_prev_r <= sel_in;
      mix_seen_r <= sel_rise ? vext_r : (mix_seen_r | vext_r);
      unmix_r    <= unmix_nxt;
    end
  end

  // Polarity and composite presence over a window of interval ticks.
  // Sync pulses are short, so a mostly-low input means positive pulses.
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      itv_r    <= 10'h000;
      win_r    <= 4'h0;
      hi_h_r   <= 5'h00;
      hi_v_r   <= 5'h00;
      hpol_r   <= 1'b0;
      vpol_r   <= 1'b0;
      c_prev_r <= 1'b0;
      cseen_r  <= 1'b0;
      cpres_r  <= 1'b0;
    end
    else
    begin
      itv_r    <= itick ? 10'h000 : itv_r + 10'h001;
      c_prev_r <= csync_i;
      if (wend)
      begin
        win_r   <= 4'h0;
        hi_h_r  <= 5'h00;
        hi_v_r  <= 5'h00;
        hpol_r  <= (hi_h_sum < msp_pkg::POL_HALF);
        vpol_r  <= (hi_v_sum < msp_pkg::POL_HALF);
        cpres_r <= cseen_r | c_edge;
        cseen_r <= 1'b0;
      end
      else
      begin
        cseen_r <= cseen_r | c_edge;
        if (itick)
        begin
          win_r  <= win_r + 4'h1;
          hi_h_r <= hi_h_sum;
          hi_v_r <= hi_v_sum;
        end
      end
    end
  end

  // Sync-on-green comparator; mismatches restart every 64 composite rises
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dly_r     <= '0;
      hn_prev_r <= 1'b1; // Matches idle hn, so no false rise after reset
      mis_r     <= 6'h00;
      cedge_r   <= 6'h00;
      green_r   <= 1'b0;
    end
    else
    begin
      dly_r     <= {dly_r[msp_pkg::GREEN_DELAY_CYC-2:0], csync_i};
      hn_prev_r <= hn;
      green_r   <= green_nxt;
      if (green_clr)
      begin
        mis_r   <= 6'h00;
        cedge_r <= 6'h00;
      end
      else
      begin
        if (c_rise)
          cedge_r <= cedge_r + 6'h01;
        if (c_rise & (cedge_r == msp_pkg::GREEN_EDGE_LAST))
          mis_r <= 6'h00;
        else if (mismatch & (mis_r != 6'h3F))
          mis_r <= mis_r + 6'h01;
      end
    end
  end

  // Clamp width counter, started from the normalised horizontal edge
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      clamp_cnt_r <= 4'h0;
    else if (clamp_go)
      clamp_cnt_r <= clamp_len(csg);
    else if (clamp_act)
      clamp_cnt_r <= clamp_cnt_r - 4'h1;
  end

  // Pseudo line and frame counters, stepped at the counter clock
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      ph_r <= 8'h00;
      pv_r <= 10'h000;
    end
    else if (ph_wrap)
    begin
      ph_r <= 8'h00;
      pv_r <= (pv_r >= msp_pkg::PV_LINES - 10'h001) ? 10'h000
                                                    : pv_r + 10'h001;
    end
    else if (ftick)
      ph_r <= ph_r + 8'h01;
  end

  // Registered outputs
  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      hs_r    <= 1'b0;
      vs_r    <= 1'b0;
      clamp_r <= 1'b1;
    end
    else
    begin
      hs_r    <= hs_src & ~outdis;
      vs_r    <= vs_src & ~outdis;
      clamp_r <= clamp_act ? cpol : ~cpol;
    end
  end

  assign s_axi_awready_o = awready_r;
  assign s_axi_wready_o  = awready_r;
  assign s_axi_bvalid_o  = bvalid_r;
  assign s_axi_bresp_o   = bresp_r;
  assign s_axi_arready_o = arready_r;
  assign s_axi_rvalid_o  = rvalid_r;
  assign s_axi_rresp_o   = rresp_r;
  assign s_axi_rdata_o   = rdata_r;
  assign hsync_o         = hs_r;
  assign vsync_o         = vs_r;
  assign clamp_o         = clamp_r;
  assign vdd_level_sel_o = two_r[msp_pkg::T_VDD];

endmodule // msp_sync_proc

// file: testbench/msp_sync_sva.sv
// Concurrent checks on the sync processor top ports.
// Assumes one clock domain, clk_i, with async active-high rst_i.
`timescale 1ns/1ns
module msp_sync_sva
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic [7:0]  s_axi_awaddr_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0]  s_axi_wstrb_i,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        hsync_i,
  input wire logic        vsync_i,
  input wire logic        csync_i,
  input wire logic        hsync_o,
  input wire logic        vsync_o,
  input wire logic        clamp_o
);
  logic       insel_r, cmp_r, hinv_r, vinv_r, cpol_r, cpol_d;
  logic       outdis_r, psdis_r, sel, act, pass_ok, cmp_ok, hexp, vexp;
  logic [1:0] cw_r;
  logic [3:0] run_r, wid;
  logic [7:0] hist_r, wd;
  assign wd      = s_axi_wdata_i[7:0];
  assign sel     = insel_r ? csync_i : hsync_i;
  assign hexp    = sel ^ hinv_r;
  assign vexp    = vsync_i ^ vinv_r;
  // Delayed polarity keeps a polarity write from looking like a pulse
  assign act     = clamp_o == cpol_d;
  assign pass_ok = psdis_r && !outdis_r && !cmp_r;
  assign cmp_ok  = cmp_r && psdis_r && !outdis_r && !vinv_r;
  assign wid     = 4'h1 << cw_r;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Shadow of control bits, taken at the edge the write is accepted
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      {insel_r, cmp_r, hinv_r, vinv_r, cpol_r, cw_r, outdis_r} <= '0;
      psdis_r <= 1'h1;
      {cpol_d, run_r, hist_r} <= '0;
    end
    else
    begin
      if (s_axi_awready_o && s_axi_wstrb_i[0])
      begin
        if (s_axi_awaddr_i == msp_pkg::ADDR_CTRL_ZERO)
          {insel_r, cmp_r} <= {wd[7], wd[5]};
        if (s_axi_awaddr_i == msp_pkg::ADDR_CTRL_ONE)
          {cw_r, cpol_r, vinv_r, hinv_r} <= {wd[7:6], wd[4:2]};
        if (s_axi_awaddr_i == msp_pkg::ADDR_CTRL_TWO)
          {psdis_r, outdis_r} <= {wd[4], wd[0]};
      end
      cpol_d <= cpol_r;
      run_r  <= act ? run_r + 4'h1 : 4'h0;
      hist_r <= {hist_r[6:0], sel};
    end
  aw_pair_a: assert property (s_axi_awready_o |-> s_axi_wready_o &&
    s_axi_awvalid_i && s_axi_wvalid_i) else $error("write taken alone");
  b_follow_a: assert property (s_axi_awready_o |=> s_axi_bvalid_o)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
    s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("bresp dropped");
  r_follow_a: assert property (s_axi_arready_o |=> s_axi_rvalid_o)
    else $error("read data late");
  r_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=>
    s_axi_rvalid_o && $stable(s_axi_rdata_o)) else $error("rdata dropped");
  out_off_a: assert property ($past(outdis_r) && !$past(rst_i) |->
    !hsync_o && !vsync_o) else $error("sync outputs not held low");
  pass_h_a: assert property ($past(pass_ok) && !$past(rst_i) |->
    hsync_o == $past(hexp)) else $error("hsync not passed through");
  pass_v_a: assert property ($past(pass_ok) && !$past(rst_i) |->
    vsync_o == $past(vexp)) else $error("vsync not passed through");
  vext_up_a: assert property ($past(cmp_ok) && $past(cmp_ok, 2) &&
    $rose(vsync_o) |-> |hist_r) else $error("vsync rose on low input");
  vext_down_a: assert property ($past(cmp_ok) && $past(cmp_ok, 2) &&
    $fell(vsync_o) |-> !(&hist_r)) else $error("vsync fell on high input");
  clamp_idle_a: assert property (cw_r == 2'h0 &&
    $past(cw_r, 8) == 2'h0 |-> !act) else $error("clamp active while off");
  clamp_width_a: assert property (!act && run_r != 4'h0 &&
    cw_r != 2'h0 |-> run_r == wid) else $error("clamp width wrong");
endmodule // msp_sync_sva

bind msp_sync_proc msp_sync_sva chk (.*);

// file: testbench/msp_video_src.sv
// Video source model driving the horizontal, vertical and composite lines.
// Assumes the bench clock; lines of 197 clocks, frames of 40 lines.
`timescale 1ns/1ns
module msp_video_src
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       en_i,
  input  wire logic       neg_i,
  input  wire logic       green_i,
  input  wire logic [2:0] lvl_i,
  output logic            hsync_o,
  output logic            vsync_o,
  output logic            csync_o
);
  logic [7:0] pix_r;
  logic [5:0] line_r;
  logic       hpul, cpul, eol;
  // Odd line length so the slow polarity samples walk across the line
  assign eol  = pix_r == 8'hC4;
  assign hpul = pix_r >= 8'h14 && pix_r < 8'h28;
  // Composite opens early, as a sync that does not ride on green does
  assign cpul = pix_r >= 8'h04 && pix_r < 8'h30;
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      {pix_r, line_r} <= '0;
      {csync_o, vsync_o, hsync_o} <= '0;
    end
    else if (!en_i)
      {csync_o, vsync_o, hsync_o} <= lvl_i;
    else
    begin
      pix_r <= eol ? 8'h00 : pix_r + 8'h01;
      if (eol)
        line_r <= (line_r == 6'h27) ? 6'h00 : line_r + 6'h01;
      hsync_o <= hpul ^ neg_i;
      vsync_o <= (line_r < 6'h03) ^ neg_i;
      // Sync riding on green gives a composite pulse as narrow as hsync
      csync_o <= green_i ? hpul : cpul;
    end
endmodule // msp_video_src

// file: testbench/testbench.sv
// Self-checking bench: AXI4-Lite register traffic and a video source.
// Assumes the design package is compiled first.
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin \
  error_cnt++; $display("wrong value at %0t: got %h expected %h", \
  $time, got, exp); end end
module testbench;
  typedef struct {logic [1:0] resp; logic [31:0] data, mask;} msp_exp_type;
  msp_exp_type q[$];
  msp_exp_type e;
  int          checks = 0, error_cnt = 0, cyc = 0, hi, per;
  logic [31:0] rnd = 32'hD0D5;
  logic        clk_i = 1'h0, rst_i = 1'h1;
  logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
  logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0;
  logic        s_axi_bready_i = 1'h0, s_axi_arvalid_i = 1'h0;
  logic        s_axi_rready_i = 1'h0, s_axi_awready_o, s_axi_wready_o;
  logic        s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        hsync_i, vsync_i, csync_i, hsync_o, vsync_o, clamp_o;
  logic        vdd_level_sel_o, en = 1'h0, neg = 1'h0, green = 1'h0;
  logic [2:0]  lvl = 3'h0;
  msp_sync_proc uut (.*);
  msp_video_src src (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .neg_i(neg),
    .lvl_i(lvl), .green_i(green), .hsync_o(hsync_i), .vsync_o(vsync_i),
    .csync_o(csync_i));
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    rst_i <= 1'h1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [1:0] r = msp_pkg::RESP_OKAY);
    @(posedge clk_i);
    q.push_back('{r, 32'h0, 32'h0});
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= {24'h0, d};
    s_axi_awvalid_i <= 1'h1;
    s_axi_wvalid_i <= 1'h1;
    s_axi_bready_i <= 1'h1;
    do @(posedge clk_i); while (s_axi_awready_o !== 1'h1);
    s_axi_awvalid_i <= 1'h0;
    s_axi_wvalid_i <= 1'h0;
    do @(posedge clk_i); while (s_axi_bvalid_o !== 1'h1);
    s_axi_bready_i <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] d,
                    input logic [1:0] r = msp_pkg::RESP_OKAY);
    @(posedge clk_i);
    q.push_back('{r, {24'h0, d}, {24'hFFFFFF, m}});
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1'h1;
    s_axi_rready_i <= 1'h1;
    do @(posedge clk_i); while (s_axi_arready_o !== 1'h1);
    s_axi_arvalid_i <= 1'h0;
    do @(posedge clk_i); while (s_axi_rvalid_o !== 1'h1);
    s_axi_rready_i <= 1'h0;
  endtask
  // Skips one pulse so a period cut by the mode change is never measured
  task automatic meas(output int h, output int p);
    repeat (2)
    begin
      while (hsync_o !== 1'h0) @(posedge clk_i);
      while (hsync_o !== 1'h1) @(posedge clk_i);
    end
    h = 0;
    while (hsync_o === 1'h1) begin h++; @(posedge clk_i); end
    p = h;
    while (hsync_o !== 1'h1) begin p++; @(posedge clk_i); end
  endtask
  always @(posedge clk_i)
  begin
    if (s_axi_bvalid_o === 1'h1 && s_axi_bready_i === 1'h1)
    begin
      e = q.pop_front();
      `CHK(s_axi_bresp_o, e.resp)
    end
    if (s_axi_rvalid_o === 1'h1 && s_axi_rready_i === 1'h1)
    begin
      e = q.pop_front();
      `CHK(s_axi_rresp_o, e.resp)
      `CHK(s_axi_rdata_o & e.mask, e.data)
    end
    cyc++;
    if (cyc == 90000)
    begin
      error_cnt++;
      end_sim();
    end
  end
  initial
  begin
    do_reset();
    `CHK(clamp_o, 1'h1)
    rd(msp_pkg::ADDR_CTRL_ZERO, 8'hFF, 8'h00);
    rd(msp_pkg::ADDR_CTRL_ONE, 8'hFF, 8'h00);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'hFF, 8'h10);
    rd(msp_pkg::ADDR_DIVISOR, 8'hFF, 8'h7F);
    rd(8'h10, 8'hFF, 8'h00, msp_pkg::RESP_SLVERR);
    wr(8'h10, 8'h5A, msp_pkg::RESP_SLVERR);
    repeat (4)
    begin
      rnd = lfsr(rnd);
      wr(msp_pkg::ADDR_CTRL_ONE, rnd[7:0]);
      rd(msp_pkg::ADDR_CTRL_ONE, 8'hFC, rnd[7:0] & 8'hFC);
      wr(msp_pkg::ADDR_DIVISOR, rnd[15:8]);
      rd(msp_pkg::ADDR_DIVISOR, 8'hFF, rnd[15:8]);
    end
    wr(msp_pkg::ADDR_CTRL_TWO, 8'h51);
    `CHK(vdd_level_sel_o, 1'h1)
    rd(msp_pkg::ADDR_CTRL_TWO, 8'hF1, 8'h51);
    do_reset();
    rd(msp_pkg::ADDR_CTRL_TWO, 8'hFF, 8'h10);
    $display("test registers done");
    lvl <= 3'h4;
    rd(msp_pkg::ADDR_CTRL_ZERO, 8'h40, 8'h00);
    wr(msp_pkg::ADDR_CTRL_ZERO, 8'h80);
    rd(msp_pkg::ADDR_CTRL_ZERO, 8'h40, 8'h40);
    wr(msp_pkg::ADDR_CTRL_ZERO, 8'h20);
    lvl <= 3'h1;
    repeat (120) @(posedge clk_i);
    rd(msp_pkg::ADDR_CTRL_ZERO, 8'hFF, 8'h7F);
    `CHK(vsync_o, 1'h1)
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h08, 8'h08);
    wr(msp_pkg::ADDR_CTRL_TWO, 8'h10);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h08, 8'h00);
    lvl <= 3'h0;
    repeat (120) @(posedge clk_i);
    rd(msp_pkg::ADDR_CTRL_ZERO, 8'hFF, 8'h20);
    `CHK(vsync_o, 1'h0)
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h08, 8'h08);
    wr(msp_pkg::ADDR_CTRL_ZERO, 8'h00);
    $display("test compare done");
    wr(msp_pkg::ADDR_DIVISOR, 8'h10);
    for (int s = 0; s < 2; s++)
    begin
      wr(msp_pkg::ADDR_CTRL_TWO, {2'h0, s[0], 5'h00});
      meas(hi, per);
      `CHK(hi, 8 * (3 - s))
      `CHK(per, 16 * (3 - s))
    end
    wr(msp_pkg::ADDR_CTRL_TWO, 8'h10);
    $display("test pseudo done");
    wr(msp_pkg::ADDR_CTRL_ONE, 8'hD0);
    en <= 1'h1;
    wr(msp_pkg::ADDR_CTRL_ZERO, 8'h20);
    repeat (33000) @(posedge clk_i);
    rd(msp_pkg::ADDR_CTRL_ONE, 8'h03, 8'h03);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h80, 8'h80);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h02, 8'h02);
    wr(msp_pkg::ADDR_CTRL_ZERO, 8'h00);
    neg <= 1'h1;
    repeat (33000) @(posedge clk_i);
    rd(msp_pkg::ADDR_CTRL_ONE, 8'h03, 8'h00);
    green <= 1'h1;
    wr(msp_pkg::ADDR_CTRL_ONE, 8'hD4);
    wr(msp_pkg::ADDR_CTRL_TWO, 8'h10);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h04, 8'h00);
    repeat (8000) @(posedge clk_i);
    rd(msp_pkg::ADDR_CTRL_TWO, 8'h04, 8'h04);
    $display("test polarity done");
    end_sim();
  end
endmodule // testbench
